// ===== core/rpc_pkg.sv
package rpc_pkg;
   localparam logic [7:0] ADDR_J_VOUT = 8'h80;
   localparam logic [7:0] ADDR_J_CTRL = 8'h81;
   localparam logic [7:0] ADDR_K_VOUT = 8'h90;
   localparam logic [7:0] ADDR_K_CTRL = 8'h91;
   localparam logic [7:0] ADDR_L_VOUT = 8'ha0;
   localparam logic [7:0] ADDR_L_CTRL = 8'ha1;
   localparam logic [7:0] ADDR_KA_CTRL = 8'hb1;
   localparam logic [7:0] ADDR_BTN_CTRL = 8'hc0;
   localparam logic [7:0] ADDR_IRQ_SRC = 8'hc1;
   localparam logic [7:0] IRQ_SRC_IDLE = 8'hff;
   // Block address reported for button events
   localparam logic [7:0] IRQ_SRC_BTN = 8'hc0;
   localparam int NUM_CH = 3;
   localparam int BIT_EN = 7;
   localparam int BIT_DIS = 2;
   localparam int BIT_FLT = 1;
   localparam int BIT_OK = 0;
   localparam int BIT_PRESS = 7;
   localparam int BIT_RELEASE = 6;
   localparam int BIT_WDSR = 1;
   localparam logic [5:0] VOUT_RST = 6'h00;
   localparam logic [7:0] CTRL_WMASK = 8'h86;
   localparam logic [7:0] BTN_WMASK = 8'hc2;

   typedef struct packed {
      logic [5:0] vout_code;
      logic enable;
      logic shutdown_discharge_en;
      logic fault_irq_enable;
   } rpc_ch_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rpc_bus_t;
endpackage

// ===== core/rpc_chan.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_chan (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register access
   input wire rpc_pkg::rpc_bus_t bus,
   input wire logic [7:0] vout_addr,
   input wire logic [7:0] ctrl_addr,
   // Analog side
   input wire logic power_good,
   input wire logic fault,
   // Outputs
   output var rpc_pkg::rpc_ch_t cfg,
   output logic discharge_on,
   output logic fault_pend
);
   typedef struct packed {
      rpc_pkg::rpc_ch_t cfg;
      logic dis;
      logic fp;
   } rpc_chst_t;
   rpc_chst_t s_q, s_d;

   // Register writes and derived controls
   always_comb begin
      s_d = s_q;
      if (bus.wr && bus.addr == vout_addr) begin
         s_d.cfg.vout_code = bus.wdata[5:0];
      end
      if (bus.wr && bus.addr == ctrl_addr) begin
         s_d.cfg.enable = bus.wdata[rpc_pkg::BIT_EN];
         s_d.cfg.shutdown_discharge_en = bus.wdata[rpc_pkg::BIT_DIS];
         s_d.cfg.fault_irq_enable = bus.wdata[rpc_pkg::BIT_FLT];
      end
      s_d.dis = !s_q.cfg.enable && s_q.cfg.shutdown_discharge_en;
      s_d.fp = fault && s_q.cfg.fault_irq_enable;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cfg = s_q.cfg;
   assign discharge_on = s_q.dis;
   assign fault_pend = s_q.fp;

   property p_dis;
      @(posedge ref_clk) disable iff (sys_rst)
      discharge_on |-> $past(!cfg.enable && cfg.shutdown_discharge_en);
   endproperty
   a_dis: assert property (p_dis) else $error("discharge while enabled");

   property p_flt;
      @(posedge ref_clk) disable iff (sys_rst)
      (fault && !cfg.fault_irq_enable) |=> !fault_pend;
   endproperty
   a_flt: assert property (p_flt) else $error("masked fault pending");
endmodule
`default_nettype wire

// ===== core/rpc_btn.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_btn (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Button and enables
   input wire logic push_button_input_n,
   input wire logic press_en,
   input wire logic release_en,
   input wire logic clear,
   // Pending event
   output logic pend
);
   typedef struct packed {
      logic prev_n;
      logic pend;
   } rpc_btst_t;
   rpc_btst_t s_q, s_d;
   logic press_ev, release_ev;

   // Edge detect; a new edge beats a clear in the same cycle
   always_comb begin
      press_ev = s_q.prev_n && !push_button_input_n && press_en;
      release_ev = !s_q.prev_n && push_button_input_n && release_en;
      s_d.prev_n = push_button_input_n;
      s_d.pend = press_ev || release_ev || (s_q.pend && !clear);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= 2'b10;
      end else begin
         s_q <= s_d;
      end
   end

   assign pend = s_q.pend;

   property p_press;
      @(posedge ref_clk) disable iff (sys_rst)
      (press_en && $fell(push_button_input_n)) |=> pend;
   endproperty
   a_press: assert property (p_press) else $error("press lost");

   property p_rel;
      @(posedge ref_clk) disable iff (sys_rst)
      (release_en && $rose(push_button_input_n)) |=> pend;
   endproperty
   a_rel: assert property (p_rel) else $error("release lost");
endmodule
`default_nettype wire

// ===== core/rpc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port from serial interface
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Regulator status inputs, one bit per channel
   input wire logic [2:0] power_good,
   input wire logic [2:0] reg_fault,
   // System inputs
   input wire logic push_button_input_n,
   input wire logic sleep_entry,
   input wire logic watchdog_expired,
   // Regulator controls
   output logic [17:0] vout_code,
   output logic [2:0] reg_enable,
   output logic [2:0] discharge_on,
   output logic keepalive_enable,
   // System outputs
   output logic soft_reset_start,
   output logic irq
);
   typedef struct packed {
      logic ka_en;
      logic press_en;
      logic release_en;
      logic wdsr_en;
      logic [7:0] irq_src;
      logic [7:0] rdata;
      logic srst;
      logic irq;
      logic [17:0] vout;
      logic [2:0] en;
      logic [2:0] dis;
   } rpc_st_t;
   rpc_st_t s_q, s_d;

   rpc_pkg::rpc_bus_t bus;
   rpc_pkg::rpc_ch_t ch_cfg [rpc_pkg::NUM_CH];
   logic [2:0] ch_dis, ch_fp;
   logic btn_pend, btn_clear;
   logic [7:0] vaddr [rpc_pkg::NUM_CH];
   logic [7:0] caddr [rpc_pkg::NUM_CH];

   assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
   assign vaddr[0] = rpc_pkg::ADDR_J_VOUT;
   assign vaddr[1] = rpc_pkg::ADDR_K_VOUT;
   assign vaddr[2] = rpc_pkg::ADDR_L_VOUT;
   assign caddr[0] = rpc_pkg::ADDR_J_CTRL;
   assign caddr[1] = rpc_pkg::ADDR_K_CTRL;
   assign caddr[2] = rpc_pkg::ADDR_L_CTRL;
   // Reading the source byte services the button event
   assign btn_clear = reg_rd && reg_addr == rpc_pkg::ADDR_IRQ_SRC;

   // One channel slice per regulator
   genvar gi;
   generate
      for (gi = 0; gi < rpc_pkg::NUM_CH; gi++) begin : g_ch
         rpc_chan u_ch (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .bus(bus),
            .vout_addr(vaddr[gi]),
            .ctrl_addr(caddr[gi]),
            .power_good(power_good[gi]),
            .fault(reg_fault[gi]),
            .cfg(ch_cfg[gi]),
            .discharge_on(ch_dis[gi]),
            .fault_pend(ch_fp[gi])
         );
      end
   endgenerate

   rpc_btn u_btn (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .push_button_input_n(push_button_input_n),
      .press_en(s_q.press_en),
      .release_en(s_q.release_en),
      .clear(btn_clear),
      .pend(btn_pend)
   );

   // Register file, read mux and system controls
   always_comb begin
      s_d = s_q;
      s_d.srst = 1'b0;
      for (int i = 0; i < rpc_pkg::NUM_CH; i++) begin
         s_d.vout[i*6 +: 6] = ch_cfg[i].vout_code;
         s_d.en[i] = ch_cfg[i].enable;
         s_d.dis[i] = ch_dis[i];
      end
      if (reg_wr) begin
         case (reg_addr)
            rpc_pkg::ADDR_KA_CTRL: begin
               s_d.ka_en = reg_wdata[rpc_pkg::BIT_EN];
            end
            rpc_pkg::ADDR_BTN_CTRL: begin
               s_d.press_en = reg_wdata[rpc_pkg::BIT_PRESS];
               s_d.release_en = reg_wdata[rpc_pkg::BIT_RELEASE];
               s_d.wdsr_en = reg_wdata[rpc_pkg::BIT_WDSR];
            end
            default: begin
            end
         endcase
      end
      // Sleep entry wins over a write in the same cycle
      if (sleep_entry) begin
         s_d.wdsr_en = 1'b0;
      end
      s_d.srst = watchdog_expired && s_q.wdsr_en;
      // Source address; a fresh event beats the read-back reset
      if (reg_rd && reg_addr == rpc_pkg::ADDR_IRQ_SRC) begin
         s_d.irq_src = rpc_pkg::IRQ_SRC_IDLE;
      end
      if (ch_fp[0]) begin
         s_d.irq_src = rpc_pkg::ADDR_J_VOUT;
      end else if (ch_fp[1]) begin
         s_d.irq_src = rpc_pkg::ADDR_K_VOUT;
      end else if (ch_fp[2]) begin
         s_d.irq_src = rpc_pkg::ADDR_L_VOUT;
      end
      s_d.irq = (|ch_fp) || btn_pend;
      // Read data, reserved bits zero
      s_d.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            rpc_pkg::ADDR_J_VOUT, rpc_pkg::ADDR_K_VOUT, rpc_pkg::ADDR_L_VOUT: begin
               for (int i = 0; i < rpc_pkg::NUM_CH; i++) begin
                  if (reg_addr == vaddr[i]) begin
                     s_d.rdata = {2'b00, ch_cfg[i].vout_code};
                  end
               end
            end
            rpc_pkg::ADDR_J_CTRL, rpc_pkg::ADDR_K_CTRL, rpc_pkg::ADDR_L_CTRL: begin
               for (int i = 0; i < rpc_pkg::NUM_CH; i++) begin
                  if (reg_addr == caddr[i]) begin
                     s_d.rdata = {ch_cfg[i].enable, 4'h0, ch_cfg[i].shutdown_discharge_en,
                                  ch_cfg[i].fault_irq_enable, power_good[i]};
                  end
               end
            end
            rpc_pkg::ADDR_KA_CTRL: begin
               s_d.rdata = {s_q.ka_en, 7'h00};
            end
            rpc_pkg::ADDR_BTN_CTRL: begin
               s_d.rdata = {s_q.press_en, s_q.release_en, 4'h0, s_q.wdsr_en, 1'b0};
            end
            rpc_pkg::ADDR_IRQ_SRC: begin
               s_d.rdata = btn_pend && s_q.irq_src == rpc_pkg::IRQ_SRC_IDLE
                  ? rpc_pkg::IRQ_SRC_BTN : s_q.irq_src;
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.irq_src <= rpc_pkg::IRQ_SRC_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // All outputs are flops
   assign reg_rdata = s_q.rdata;
   assign vout_code = s_q.vout;
   assign reg_enable = s_q.en;
   assign discharge_on = s_q.dis;
   assign keepalive_enable = s_q.ka_en;
   assign soft_reset_start = s_q.srst;
   assign irq = s_q.irq;

   property p_sleep;
      @(posedge ref_clk) disable iff (sys_rst)
      sleep_entry |=> !s_q.wdsr_en;
   endproperty
   a_sleep: assert property (p_sleep) else $error("enable kept past sleep");

   property p_wd;
      @(posedge ref_clk) disable iff (sys_rst)
      (watchdog_expired && s_q.wdsr_en) |=> soft_reset_start;
   endproperty
   a_wd: assert property (p_wd) else $error("no soft reset");

   property p_wdoff;
      @(posedge ref_clk) disable iff (sys_rst)
      !s_q.wdsr_en |=> !soft_reset_start;
   endproperty
   a_wdoff: assert property (p_wdoff) else $error("soft reset while off");

   property p_src;
      @(posedge ref_clk) disable iff (sys_rst)
      (btn_clear && ch_fp == 3'b000) |=> s_q.irq_src == rpc_pkg::IRQ_SRC_IDLE;
   endproperty
   a_src: assert property (p_src) else $error("source not restored");

   property p_irq;
      @(posedge ref_clk) disable iff (sys_rst)
      (btn_pend || ch_fp != 3'b000) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_ka;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == rpc_pkg::ADDR_KA_CTRL) |=> reg_rdata[6:0] == 7'h00;
   endproperty
   a_ka: assert property (p_ka) else $error("keepalive reserved nonzero");

   property p_en;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == rpc_pkg::ADDR_J_CTRL) |=> ##1 reg_enable[0] == $past(reg_wdata[7], 2);
   endproperty
   a_en: assert property (p_en) else $error("enable not taken");

   property p_vout;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == rpc_pkg::ADDR_K_VOUT) |=> ##1 vout_code[11:6] == $past(reg_wdata[5:0], 2);
   endproperty
   a_vout: assert property (p_vout) else $error("vout code not taken");

   // Read-back image, reserved bits, register writes and derived outputs
   property p_rd_idle;
      @(posedge ref_clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

   property p_ctrl_rsv;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && (reg_addr == rpc_pkg::ADDR_J_CTRL || reg_addr == rpc_pkg::ADDR_K_CTRL
         || reg_addr == rpc_pkg::ADDR_L_CTRL)) |=> reg_rdata[6:3] == 4'h0;
   endproperty
   a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control reserved nonzero");

   property p_vout_rsv;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == rpc_pkg::ADDR_L_VOUT) |=> reg_rdata[7:6] == 2'b00;
   endproperty
   a_vout_rsv: assert property (p_vout_rsv) else $error("vout reserved nonzero");

   property p_btn_rsv;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == rpc_pkg::ADDR_BTN_CTRL) |=> reg_rdata[5:2] == 4'h0 && !reg_rdata[0];
   endproperty
   a_btn_rsv: assert property (p_btn_rsv) else $error("button reserved nonzero");

   property p_pg;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == rpc_pkg::ADDR_J_CTRL) |=> reg_rdata[0] == $past(power_good[0]);
   endproperty
   a_pg: assert property (p_pg) else $error("power-good bit wrong");

   property p_press_wr;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == rpc_pkg::ADDR_BTN_CTRL)
         |=> s_q.press_en == $past(reg_wdata[rpc_pkg::BIT_PRESS]);
   endproperty
   a_press_wr: assert property (p_press_wr) else $error("press enable not taken");

   property p_rel_wr;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == rpc_pkg::ADDR_BTN_CTRL)
         |=> s_q.release_en == $past(reg_wdata[rpc_pkg::BIT_RELEASE]);
   endproperty
   a_rel_wr: assert property (p_rel_wr) else $error("release enable not taken");

   property p_wdsr_wr;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == rpc_pkg::ADDR_BTN_CTRL && !sleep_entry)
         |=> s_q.wdsr_en == $past(reg_wdata[rpc_pkg::BIT_WDSR]);
   endproperty
   a_wdsr_wr: assert property (p_wdsr_wr) else $error("watchdog enable not taken");

   property p_ka_wr;
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == rpc_pkg::ADDR_KA_CTRL)
         |=> keepalive_enable == $past(reg_wdata[rpc_pkg::BIT_EN]);
   endproperty
   a_ka_wr: assert property (p_ka_wr) else $error("keepalive enable not taken");

   property p_dis_out;
      @(posedge ref_clk) disable iff (sys_rst)
      discharge_on[0] |-> $past(!ch_cfg[0].enable && ch_cfg[0].shutdown_discharge_en, 2);
   endproperty
   a_dis_out: assert property (p_dis_out) else $error("discharge output wrong");

   property p_irq_off;
      @(posedge ref_clk) disable iff (sys_rst)
      (!btn_pend && ch_fp == 3'b000) |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq without event");

   property p_src_l;
      @(posedge ref_clk) disable iff (sys_rst)
      (ch_fp == 3'b100) |=> s_q.irq_src == rpc_pkg::ADDR_L_VOUT;
   endproperty
   a_src_l: assert property (p_src_l) else $error("fault source wrong");

   property p_src_rd;
      @(posedge ref_clk) disable iff (sys_rst)
      (btn_clear && !btn_pend) |=> reg_rdata == $past(s_q.irq_src);
   endproperty
   a_src_rd: assert property (p_src_rd) else $error("source read-back wrong");

   property p_srst_src;
      @(posedge ref_clk) disable iff (sys_rst)
      soft_reset_start |-> $past(watchdog_expired && s_q.wdsr_en);
   endproperty
   a_srst_src: assert property (p_srst_src) else $error("soft reset without cause");
endmodule
`default_nettype wire

// ===== tb/rpc_plant.sv
`timescale 1ns/10ps
`default_nettype none
// Regulator stand-in: power-good after a ramp, fault on command
module rpc_plant #(
   parameter int RAMP = 3
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // From the bank and the bench
   input wire logic [2:0] reg_enable,
   input wire logic [2:0] fault_cmd,
   // Status back to the bank
   output logic [2:0] power_good,
   output logic [2:0] reg_fault
);
   logic [2:0][3:0] ramp_q;
   // Output collapses at once on disable, so status must follow quickly
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ramp_q <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (!reg_enable[i]) ramp_q[i] <= 4'h0;
            else if (ramp_q[i] != 4'(RAMP)) ramp_q[i] <= ramp_q[i] + 4'h1;
         end
      end
   end
   // Status lines
   always_comb begin
      for (int i = 0; i < 3; i++) power_good[i] = (ramp_q[i] == 4'(RAMP));
      reg_fault = fault_cmd;
   end
endmodule
`default_nettype wire

// ===== tb/rpc_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_regs_tb;
   logic ref_clk, sys_rst, reg_wr, reg_rd, keepalive_enable, soft_reset_start, irq;
   logic push_button_input_n, sleep_entry, watchdog_expired;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] power_good, reg_fault, fault_cmd, reg_enable, discharge_on;
   logic [17:0] vout_code;
   int n_errors, tests_run, cycles;

   rpc_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .power_good(power_good), .reg_fault(reg_fault),
      .push_button_input_n(push_button_input_n), .sleep_entry(sleep_entry),
      .watchdog_expired(watchdog_expired), .vout_code(vout_code), .reg_enable(reg_enable),
      .discharge_on(discharge_on), .keepalive_enable(keepalive_enable),
      .soft_reset_start(soft_reset_start), .irq(irq));
   rpc_plant plant (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_enable(reg_enable),
      .fault_cmd(fault_cmd), .power_good(power_good), .reg_fault(reg_fault));

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Hang guard, well above the hundred or so cycles needed
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic close_out;
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // One-cycle strobes; data is held through the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   // Read data stands only in the cycle after the taking edge
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk($sformatf("read %h", a), 18'(exp), 18'(reg_rdata));
   endtask
   task automatic wait_irq(input logic lvl);
      int k;
      k = 0;
      while (irq !== lvl && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      chk("irq", 18'(lvl), 18'(irq));
   endtask

   // Main sequence
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, fault_cmd, sleep_entry, watchdog_expired} = '0;
      push_button_input_n = 1'b1;
      sys_rst = 1'b1;
      repeat (4) @(negedge ref_clk);
      sys_rst = 1'b0;
      // Reset state and an unmapped byte
      rdc(8'h80, 8'h00);
      rdc(8'h81, 8'h00);
      rdc(8'hb1, 8'h00);
      rdc(8'hc0, 8'h00);
      rdc(8'hc1, 8'hff);
      rdc(8'h82, 8'h00);
      // Voltage codes with reserved bits written high, except bit 7 of the a0 code
      wr(8'h80, 8'hff);
      wr(8'h90, 8'hc5);
      wr(8'ha0, 8'h6a);
      rdc(8'h80, 8'h3f);
      rdc(8'h90, 8'h05);
      rdc(8'ha0, 8'h2a);
      chk("vout_code", {6'h2a, 6'h05, 6'h3f}, vout_code);
      // Enable all three, power-good follows the ramp
      wr(8'h81, 8'hff);
      wr(8'h91, 8'h86);
      wr(8'ha1, 8'h84);
      cyc(6);
      chk("reg_enable", 18'h7, 18'(reg_enable));
      chk("discharge_on", 18'h0, 18'(discharge_on));
      rdc(8'h81, 8'h87);
      rdc(8'h91, 8'h87);
      rdc(8'ha1, 8'h85);
      // Shut down j with discharge, k without
      wr(8'h81, 8'h04);
      wr(8'h91, 8'h00);
      cyc(3);
      chk("discharge_on", 18'h1, 18'(discharge_on));
      chk("reg_enable", 18'h4, 18'(reg_enable));
      rdc(8'h81, 8'h04);
      // Faults: masked channels stay quiet, unmasked one reports its address
      wr(8'ha1, 8'h86);
      fault_cmd = 3'b011;
      cyc(4);
      chk("irq", 18'h0, 18'(irq));
      fault_cmd = 3'b111;
      wait_irq(1'b1);
      fault_cmd = 3'b000;
      wait_irq(1'b0);
      rdc(8'hc1, 8'ha0);
      rdc(8'hc1, 8'hff);
      // Keepalive holds only its enable
      wr(8'hb1, 8'hff);
      rdc(8'hb1, 8'h80);
      chk("keepalive_enable", 18'h1, 18'(keepalive_enable));
      // Button edges, serviced by reading the source byte
      wr(8'hc0, 8'hff);
      rdc(8'hc0, 8'hc2);
      push_button_input_n = 1'b0;
      wait_irq(1'b1);
      rdc(8'hc1, 8'hc0);
      wait_irq(1'b0);
      push_button_input_n = 1'b1;
      wait_irq(1'b1);
      rdc(8'hc1, 8'hc0);
      wait_irq(1'b0);
      wr(8'hc0, 8'h02);
      push_button_input_n = 1'b0;
      cyc(4);
      chk("irq", 18'h0, 18'(irq));
      push_button_input_n = 1'b1;
      cyc(4);
      chk("irq", 18'h0, 18'(irq));
      // Watchdog expiry, then sleep clears the enable
      watchdog_expired = 1'b1;
      cyc(1);
      watchdog_expired = 1'b0;
      chk("soft_reset_start", 18'h1, 18'(soft_reset_start));
      sleep_entry = 1'b1;
      cyc(1);
      sleep_entry = 1'b0;
      rdc(8'hc0, 8'h00);
      watchdog_expired = 1'b1;
      cyc(1);
      watchdog_expired = 1'b0;
      chk("soft_reset_start", 18'h0, 18'(soft_reset_start));
      close_out();
   end
endmodule
`default_nettype wire
